/* File: bench/cic_props.sv */
// assertions on the contact input conditioner ports
`timescale 1ns/1ns
`default_nettype none
module cic_props #(
    parameter int NUM_INPUTS = 48,
    parameter int CYCLES_PER_MS = 50000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_INPUTS-1:0] contact_input,
    input wire logic analog_fault_trigger,
    input wire logic [NUM_INPUTS-1:0] pulse_strobe,
    input wire logic [NUM_INPUTS-1:0] event_sequence_log_strobe,
    input wire logic [NUM_INPUTS-1:0] event_sequence_log_state,
    input wire logic ext_trigger_event,
    input wire logic fault_record_start,
    input wire logic fault_log_write,
    input wire logic ext_trigger_static
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence locked_soon;
        ##[0:1] ext_trigger_static;
    endsequence
    ready_always_a: assert property (psel |-> pready)
        else $error("pready low");
    unmapped_err_a: assert property (psel && penable && paddr == 12'h038 |-> pslverr)
        else $error("no error on unmapped address");
    trig_log_pair_a: assert property (ext_trigger_event == fault_log_write)
        else $error("fault log write not paired with trigger");
    trig_locks_a: assert property (ext_trigger_event |-> locked_soon)
        else $error("trigger without lockout");
    lock_no_trig_a: assert property (ext_trigger_static && $past(ext_trigger_static)
        |-> !ext_trigger_event)
        else $error("trigger while locked");
    trig_cause_a: assert property (ext_trigger_event
        |-> (event_sequence_log_state & ~$past(event_sequence_log_state)) != '0)
        else $error("trigger without a closing input");
    rec_cause_a: assert property (fault_record_start
        |-> ext_trigger_event || $past(analog_fault_trigger))
        else $error("recording without a trigger");
    strobe_single_a: assert property ((pulse_strobe & $past(pulse_strobe)) == '0)
        else $error("pulse strobe longer than one cycle");
    log_edge_a: assert property ((event_sequence_log_strobe
        & ~(event_sequence_log_state ^ $past(event_sequence_log_state))) == '0)
        else $error("log strobe without a state change");
    pulse_edge_a: assert property ((pulse_strobe
        & ~(event_sequence_log_state ^ $past(event_sequence_log_state))) == '0)
        else $error("pulse strobe without a state change");
endmodule // cic_props
bind contact_input_conditioner cic_props #(
    .NUM_INPUTS(NUM_INPUTS),
    .CYCLES_PER_MS(CYCLES_PER_MS)
) props_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_input(contact_input), .analog_fault_trigger(analog_fault_trigger),
    .pulse_strobe(pulse_strobe), .event_sequence_log_strobe(event_sequence_log_strobe),
    .event_sequence_log_state(event_sequence_log_state),
    .ext_trigger_event(ext_trigger_event), .fault_record_start(fault_record_start),
    .fault_log_write(fault_log_write), .ext_trigger_static(ext_trigger_static)
);
`default_nettype wire

/* File: bench/field_contacts.sv */
// field contact model: every change chatters for a few cycles
`timescale 1ns/1ns
`default_nettype none
module field_contacts (
    input wire logic pclk,
    input wire logic [47:0] want,
    output logic [47:0] contact
);
    logic [47:0] last = 48'h0;
    logic [47:0] chg = 48'h0;
    int cnt = 0;
    initial contact = 48'h0;
    always @(posedge pclk) begin
        if (want !== last) begin
            chg <= want ^ last;
            last <= want;
            cnt <= 6;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        contact <= cnt[0] ? (last ^ chg) : last;
    end
endmodule // field_contacts
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the contact input conditioner
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int CPM = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic analog = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [47:0] want = 48'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, trig, rec, flw, stat;
    logic [47:0] contact, pulse, logs, lstate;
    int n_fail = 0;
    int n_checks = 0;
    int c_trig = 0;
    int c_rec = 0;
    int c_flw = 0;
    int c_p[48];
    int c_l[48];
    int b, bl, t, r, n, f;
    always #10 pclk = ~pclk;
    field_contacts fc_u (.pclk(pclk), .want(want), .contact(contact));
    contact_input_conditioner #(.CYCLES_PER_MS(CPM)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contact_input(contact), .analog_fault_trigger(analog),
        .pulse_strobe(pulse), .event_sequence_log_strobe(logs),
        .event_sequence_log_state(lstate), .ext_trigger_event(trig),
        .fault_record_start(rec), .fault_log_write(flw), .ext_trigger_static(stat)
    );
    always @(posedge pclk) begin
        // non-blocking so the test process reads counts without a race
        c_trig <= c_trig + int'(trig === 1'b1);
        c_rec <= c_rec + int'(rec === 1'b1);
        c_flw <= c_flw + int'(flw === 1'b1);
        for (int i = 0; i < 48; i++) begin
            c_p[i] <= c_p[i] + int'(pulse[i] === 1'b1);
            c_l[i] <= c_l[i] + int'(logs[i] === 1'b1);
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    task move(input int i, input logic v);
        @(posedge pclk);
        want[i] <= v;
        repeat (80) @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h014, 32'h0000FFFF);
        rd(12'h018, 32'h0);
        rd(12'h040, 32'h1);
        rd(12'h030, 32'h0);
        xfer(1'b0, 12'h038, 32'h0);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        xfer(1'b1, 12'h028, 32'hFFFFFFFF);
        rd(12'h028, 32'h0);
        for (int g = 0; g < 6; g++) begin
            xfer(1'b1, 12'h024, 32'((g * 8 + 7) << 8) | 32'(g + 2));
            rd(12'h040 + 12'(4 * g), 32'(g + 2));
        end
        xfer(1'b1, 12'h024, 32'h0000_0000);
        rd(12'h040, 32'h1);
        xfer(1'b1, 12'h024, 32'h0000_287F);
        rd(12'h054, 32'h64);
        b = c_l[0];
        @(posedge pclk);
        want[0] <= 1'b1;
        n = 0;
        while (c_l[0] == b && n < 500) begin
            @(posedge pclk);
            n++;
        end
        // chatter 8, sync 2, then 1 to 2 ms of ticks, then strobe and count
        check(32'(n >= CPM + 12 && n <= 2 * CPM + 14), 32'h1);
        rd(12'h028, 32'h1);
        move(0, 1'b0);
        b = c_l[9];
        @(posedge pclk);
        want[9] <= 1'b1;
        repeat (4) @(posedge pclk);
        want[9] <= 1'b0;
        repeat (80) @(posedge pclk);
        check(32'(c_l[9] - b), 32'h0);
        for (int m = 0; m < 3; m++) begin
            xfer(1'b1, 12'h004, (m == 2) ? 32'h100 : 32'h0);
            xfer(1'b1, 12'h00C, (m > 0) ? 32'h100 : 32'h0);
            b = c_p[8];
            bl = c_l[8];
            move(8, 1'b1);
            check(32'(c_p[8] - b), 32'(m != 1));
            b = c_p[8];
            move(8, 1'b0);
            check(32'(c_p[8] - b), 32'(m > 0));
            check(32'(c_l[8] - bl), 32'h2);
        end
        b = c_l[20];
        move(20, 1'b1);
        move(20, 1'b0);
        check(32'(c_l[20] - b), 32'h0);
        xfer(1'b1, 12'h01C, 32'h0030_0000);
        b = c_l[20];
        t = c_trig;
        r = c_rec;
        f = c_flw;
        move(20, 1'b1);
        check(32'(c_l[20] - b), 32'h1);
        check(32'(c_trig - t), 32'h1);
        check(32'(c_flw - f), 32'h1);
        check(32'(c_rec - r), 32'h0);
        rd(12'h030, 32'h3);
        check(32'(stat), 32'h1);
        check(32'(lstate[21:20]), 32'h1);
        b = c_l[21];
        move(21, 1'b1);
        move(20, 1'b0);
        check(32'(c_trig - t), 32'h1);
        check(32'(c_l[21] - b), 32'h1);
        rd(12'h030, 32'h3);
        xfer(1'b1, 12'h000, 32'h1);
        @(posedge pclk);
        analog <= 1'b1;
        @(posedge pclk);
        analog <= 1'b0;
        repeat (4) @(posedge pclk);
        check(32'(c_rec - r), 32'h1);
        move(21, 1'b0);
        rd(12'h030, 32'h0);
        check(32'(stat), 32'h0);
        check(32'(lstate[21:20]), 32'h0);
        t = c_trig;
        r = c_rec;
        f = c_flw;
        @(posedge pclk);
        want[21:20] <= 2'b11;
        repeat (80) @(posedge pclk);
        check(32'(c_trig - t), 32'h1);
        check(32'(c_flw - f), 32'h1);
        check(32'(c_rec - r), 32'h1);
        complete_run();
    end
endmodule // testbench
`default_nettype wire

/* File: hw/cic_debounce.sv */
// one contact input: synchroniser, debounce timer and edge strobes
`timescale 1ns/1ns
`default_nettype none
`include "contact_input_conditioner_params.svh"
module cic_debounce (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw_in,
    input wire logic ms_tick,
    input wire logic [6:0] deb_ms,
    output logic state,
    output logic rise,
    output logic fall
);
    logic sync1_reg;
    logic sync2_reg;
    logic state_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic rise_next;
    logic fall_next;

    always_comb begin
        state_next = state;
        cnt_next = cnt_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (sync2_reg == state) begin
            cnt_next = 7'h00;
        end else if (ms_tick) begin
            // accept on the tick after D whole ticks, so the input held at least D ms
            if (cnt_reg >= deb_ms) begin
                cnt_next = 7'h00;
                state_next = sync2_reg;
                rise_next = sync2_reg;
                fall_next = ~sync2_reg;
            end else begin
                cnt_next = cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            state <= 1'b0;
            cnt_reg <= 7'h00;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            state <= state_next;
            cnt_reg <= cnt_next;
            rise <= rise_next;
            fall <= fall_next;
        end
    end
endmodule // cic_debounce
`default_nettype wire

/* File: hw/cic_ms_tick.sv */
// millisecond tick generator from the bus clock
`timescale 1ns/1ns
`default_nettype none
`include "contact_input_conditioner_params.svh"
module cic_ms_tick #(
    parameter int CYCLES_PER_MS = `CIC_CYCLES_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg >= 32'(CYCLES_PER_MS - 1)) begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule // cic_ms_tick
`default_nettype wire

/* File: hw/cic_pkg.sv */
// types for the contact input conditioner
package cic_pkg;
    typedef enum logic [1:0] {
        TRIG_ARMED = 2'b01,
        TRIG_LOCKED = 2'b10
    } trig_state_t;
endpackage

/* File: hw/contact_input_conditioner.sv */
// contact input conditioner: debounce, pulse detect, event log and fault trigger
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "contact_input_conditioner_params.svh"
module contact_input_conditioner #(
    parameter int NUM_INPUTS = `CIC_NUM_INPUTS,
    parameter int CYCLES_PER_MS = `CIC_CYCLES_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_INPUTS-1:0] contact_input,
    input wire logic analog_fault_trigger,
    output logic [NUM_INPUTS-1:0] pulse_strobe,
    output logic [NUM_INPUTS-1:0] event_sequence_log_strobe,
    output logic [NUM_INPUTS-1:0] event_sequence_log_state,
    output logic ext_trigger_event,
    output logic fault_record_start,
    output logic fault_log_write,
    output logic ext_trigger_static
);
    localparam int NUM_GROUPS = (NUM_INPUTS + `CIC_GROUP_SIZE - 1) / `CIC_GROUP_SIZE;

    logic ms_tick;
    logic [NUM_INPUTS-1:0] deb_state;
    logic [NUM_INPUTS-1:0] deb_rise;
    logic [NUM_INPUTS-1:0] deb_fall;

    // configuration registers
    logic recorder_en_reg;
    logic recorder_en_next;
    logic [NUM_INPUTS-1:0] mode_reg;
    logic [NUM_INPUTS-1:0] mode_next;
    logic [NUM_INPUTS-1:0] pol_reg;
    logic [NUM_INPUTS-1:0] pol_next;
    logic [NUM_INPUTS-1:0] log_en_reg;
    logic [NUM_INPUTS-1:0] log_en_next;
    logic [NUM_INPUTS-1:0] link_reg;
    logic [NUM_INPUTS-1:0] link_next;
    logic [6:0] deb_ms_reg [NUM_GROUPS];
    logic [6:0] deb_ms_next [NUM_GROUPS];
    logic [5:0] deb_sel_reg;
    logic [5:0] deb_sel_next;
    logic [31:0] prdata_next;

    // trigger state
    cic_pkg::trig_state_t trig_reg;
    cic_pkg::trig_state_t trig_next;
    logic ext_trig_next;
    logic rec_start_next;
    logic static_next;
    logic [NUM_INPUTS-1:0] pulse_next;
    logic [NUM_INPUTS-1:0] log_strobe_next;

    logic [63:0] mode_w;
    logic [63:0] pol_w;
    logic [63:0] log_w;
    logic [63:0] link_w;
    logic [63:0] state_w;
    logic wr;
    logic rd;
    logic [6:0] wr_ms;

    cic_ms_tick #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(ms_tick)
    );

    // one debouncer per input, numbered in module connection order
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            cic_debounce u_deb (
                .pclk(pclk),
                .presetn(presetn),
                .raw_in(contact_input[gi]),
                .ms_tick(ms_tick),
                .deb_ms(deb_ms_reg[gi / `CIC_GROUP_SIZE]),
                .state(deb_state[gi]),
                .rise(deb_rise[gi]),
                .fall(deb_fall[gi])
            );
        end
    endgenerate

    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign mode_w = 64'(mode_reg);
    assign pol_w = 64'(pol_reg);
    assign log_w = 64'(log_en_reg);
    assign link_w = 64'(link_reg);
    assign state_w = 64'(deb_state);

    // clamp debounce writes into the legal range
    always_comb begin
        wr_ms = pwdata[6:0];
        if (wr_ms < `CIC_DEB_MIN_MS) begin
            wr_ms = `CIC_DEB_MIN_MS;
        end else if (wr_ms > `CIC_DEB_MAX_MS) begin
            wr_ms = `CIC_DEB_MAX_MS;
        end
    end

    // register writes
    always_comb begin
        recorder_en_next = recorder_en_reg;
        mode_next = mode_reg;
        pol_next = pol_reg;
        log_en_next = log_en_reg;
        link_next = link_reg;
        deb_sel_next = deb_sel_reg;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            deb_ms_next[g] = deb_ms_reg[g];
        end
        if (wr) begin
            case (paddr)
                `CIC_ADDR_CTRL: recorder_en_next = pwdata[0];
                `CIC_ADDR_MODE_LO: mode_next = NUM_INPUTS'({mode_w[63:32], pwdata});
                `CIC_ADDR_MODE_HI: mode_next = NUM_INPUTS'({pwdata, mode_w[31:0]});
                `CIC_ADDR_POL_LO: pol_next = NUM_INPUTS'({pol_w[63:32], pwdata});
                `CIC_ADDR_POL_HI: pol_next = NUM_INPUTS'({pwdata, pol_w[31:0]});
                `CIC_ADDR_LOG_LO: log_en_next = NUM_INPUTS'({log_w[63:32], pwdata});
                `CIC_ADDR_LOG_HI: log_en_next = NUM_INPUTS'({pwdata, log_w[31:0]});
                `CIC_ADDR_LINK_LO: link_next = NUM_INPUTS'({link_w[63:32], pwdata});
                `CIC_ADDR_LINK_HI: link_next = NUM_INPUTS'({pwdata, link_w[31:0]});
                `CIC_ADDR_DEB_SEL: begin
                    // per-input debounce write lands on the whole group
                    deb_sel_next = pwdata[13:8];
                    if (32'(pwdata[13:8]) < NUM_INPUTS) begin
                        deb_ms_next[32'(pwdata[13:8]) / `CIC_GROUP_SIZE] = wr_ms;
                    end
                end
                default: begin
                    for (int g = 0; g < NUM_GROUPS; g++) begin
                        if (paddr == `CIC_ADDR_DEB_BASE + 12'(4 * g)) begin
                            deb_ms_next[g] = wr_ms;
                        end
                    end
                end
            endcase
        end
    end

    // register reads, latched in the setup cycle
    always_comb begin
        prdata_next = prdata;
        if (rd) begin
            prdata_next = 32'h0;
            case (paddr)
                `CIC_ADDR_CTRL: prdata_next = {31'h0, recorder_en_reg};
                `CIC_ADDR_MODE_LO: prdata_next = mode_w[31:0];
                `CIC_ADDR_MODE_HI: prdata_next = mode_w[63:32];
                `CIC_ADDR_POL_LO: prdata_next = pol_w[31:0];
                `CIC_ADDR_POL_HI: prdata_next = pol_w[63:32];
                `CIC_ADDR_LOG_LO: prdata_next = log_w[31:0];
                `CIC_ADDR_LOG_HI: prdata_next = log_w[63:32];
                `CIC_ADDR_LINK_LO: prdata_next = link_w[31:0];
                `CIC_ADDR_LINK_HI: prdata_next = link_w[63:32];
                `CIC_ADDR_DEB_SEL: prdata_next = {18'h0, deb_sel_reg, 1'b0,
                    deb_ms_reg[32'(deb_sel_reg) / `CIC_GROUP_SIZE % NUM_GROUPS]};
                `CIC_ADDR_STATE_LO: prdata_next = state_w[31:0];
                `CIC_ADDR_STATE_HI: prdata_next = state_w[63:32];
                `CIC_ADDR_STATUS: prdata_next = {30'h0, ext_trigger_static,
                    trig_reg == cic_pkg::TRIG_LOCKED};
                default: begin
                    for (int g = 0; g < NUM_GROUPS; g++) begin
                        if (paddr == `CIC_ADDR_DEB_BASE + 12'(4 * g)) begin
                            prdata_next = {25'h0, deb_ms_reg[g]};
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        pslverr = 1'b1;
        case (paddr)
            `CIC_ADDR_CTRL, `CIC_ADDR_MODE_LO, `CIC_ADDR_MODE_HI, `CIC_ADDR_POL_LO,
            `CIC_ADDR_POL_HI, `CIC_ADDR_LOG_LO, `CIC_ADDR_LOG_HI, `CIC_ADDR_LINK_LO,
            `CIC_ADDR_LINK_HI, `CIC_ADDR_DEB_SEL, `CIC_ADDR_STATE_LO,
            `CIC_ADDR_STATE_HI, `CIC_ADDR_STATUS: pslverr = 1'b0;
            default: begin
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (paddr == `CIC_ADDR_DEB_BASE + 12'(4 * g)) begin
                        pslverr = 1'b0;
                    end
                end
            end
        endcase
        pslverr = pslverr & psel & penable;
    end

    // pulse counting and event log strobes
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (mode_reg[i]) begin
                pulse_next[i] = deb_rise[i] | deb_fall[i];
            end else if (pol_reg[i]) begin
                pulse_next[i] = deb_fall[i];
            end else begin
                pulse_next[i] = deb_rise[i];
            end
            // both edges, independent of pulse settings
            log_strobe_next[i] = (deb_rise[i] | deb_fall[i])
                & (log_en_reg[i] | link_reg[i]);
        end
    end

    // external fault trigger with lockout until all linked inputs open
    always_comb begin
        trig_next = trig_reg;
        ext_trig_next = 1'b0;
        case (trig_reg)
            cic_pkg::TRIG_ARMED: begin
                if ((deb_rise & link_reg) != '0) begin
                    ext_trig_next = 1'b1;
                    trig_next = cic_pkg::TRIG_LOCKED;
                end
            end
            cic_pkg::TRIG_LOCKED: begin
                if ((deb_state & link_reg) == '0) begin
                    trig_next = cic_pkg::TRIG_ARMED;
                end
            end
            default: trig_next = cic_pkg::TRIG_ARMED;
        endcase
        rec_start_next = (ext_trig_next | analog_fault_trigger) & recorder_en_reg;
        static_next = trig_next == cic_pkg::TRIG_LOCKED;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recorder_en_reg <= 1'b0;
            mode_reg <= '0;
            pol_reg <= '0;
            log_en_reg <= NUM_INPUTS'(`CIC_LOG_EN_RESET);
            link_reg <= '0;
            deb_sel_reg <= 6'h00;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                deb_ms_reg[g] <= `CIC_DEB_RESET_MS;
            end
            prdata <= 32'h0;
            trig_reg <= cic_pkg::TRIG_ARMED;
            ext_trigger_event <= 1'b0;
            fault_record_start <= 1'b0;
            fault_log_write <= 1'b0;
            ext_trigger_static <= 1'b0;
            pulse_strobe <= '0;
            event_sequence_log_strobe <= '0;
            event_sequence_log_state <= '0;
        end else begin
            recorder_en_reg <= recorder_en_next;
            mode_reg <= mode_next;
            pol_reg <= pol_next;
            log_en_reg <= log_en_next;
            link_reg <= link_next;
            deb_sel_reg <= deb_sel_next;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                deb_ms_reg[g] <= deb_ms_next[g];
            end
            prdata <= prdata_next;
            trig_reg <= trig_next;
            ext_trigger_event <= ext_trig_next;
            fault_record_start <= rec_start_next;
            fault_log_write <= ext_trig_next;
            ext_trigger_static <= static_next;
            pulse_strobe <= pulse_next;
            event_sequence_log_strobe <= log_strobe_next;
            event_sequence_log_state <= deb_state;
        end
    end
endmodule // contact_input_conditioner
`default_nettype wire

/* File: hw/contact_input_conditioner_params.svh */
// constants for the contact input conditioner
`ifndef CONTACT_INPUT_CONDITIONER_PARAMS_SVH
`define CONTACT_INPUT_CONDITIONER_PARAMS_SVH
`define CIC_NUM_INPUTS 48
`define CIC_INPUTS_PER_MODULE 16
`define CIC_GROUP_SIZE 8
`define CIC_NUM_GROUPS 6
`define CIC_CLK_HZ 50000000
`define CIC_MS_PER_S 1000
`define CIC_CYCLES_PER_MS (`CIC_CLK_HZ / `CIC_MS_PER_S)
`define CIC_DEB_MIN_MS 7'h01
`define CIC_DEB_MAX_MS 7'h64
`define CIC_DEB_RESET_MS 7'h01
`define CIC_LOG_EN_RESET 48'h0000_0000_FFFF
`define CIC_ADDR_CTRL 12'h000
`define CIC_ADDR_MODE_LO 12'h004
`define CIC_ADDR_MODE_HI 12'h008
`define CIC_ADDR_POL_LO 12'h00C
`define CIC_ADDR_POL_HI 12'h010
`define CIC_ADDR_LOG_LO 12'h014
`define CIC_ADDR_LOG_HI 12'h018
`define CIC_ADDR_LINK_LO 12'h01C
`define CIC_ADDR_LINK_HI 12'h020
`define CIC_ADDR_DEB_SEL 12'h024
`define CIC_ADDR_STATE_LO 12'h028
`define CIC_ADDR_STATE_HI 12'h02C
`define CIC_ADDR_STATUS 12'h030
`define CIC_ADDR_DEB_BASE 12'h040
`endif
